// ### verilog/lvdss_pkg.sv
package lvdss_pkg;

  // Parallel pixel word, 21 bits, red in the top bits
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
    logic       line_sync;
    logic       frame_sync;
    logic       pixel_data_valid;
  } lvdss_pixel_s;

  localparam int unsigned PIXEL_BITS    = 21;
  localparam int unsigned LANES         = 3;
  localparam int unsigned BITS_PER_LANE = 7;
  localparam int unsigned SHIFT_LANES   = LANES + 1;

  // Sampled-pin vector: pixel word, then clock, strobe select, power down
  localparam int unsigned PIN_W        = PIXEL_BITS + 3;
  localparam int unsigned PIN_CLK      = PIXEL_BITS;
  localparam int unsigned PIN_SEL      = PIXEL_BITS + 1;
  localparam int unsigned PIN_PD       = PIXEL_BITS + 2;

  localparam int unsigned PERIOD_W     = 8;
  localparam int unsigned ACC_W        = PERIOD_W + 1;
  localparam int unsigned IDX_W        = 3;
  localparam logic [IDX_W-1:0] LAST_BIT = 3'h6;
  localparam logic [ACC_W-1:0] ACC_STEP = 9'h007;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hFF;

  // Forwarded clock shape over one seven-bit frame, sent first bit first
  localparam logic [BITS_PER_LANE-1:0] FWD_CLK_PATTERN = 7'h63;

  // Multiplier lock wait
  localparam int unsigned SYS_CLK_KHZ   = 125000;
  localparam int unsigned LOCK_TIME_MS  = 10;
  localparam int unsigned LOCK_CYCLES_DEF = LOCK_TIME_MS * SYS_CLK_KHZ;
  localparam int unsigned LOCK_W        = 21;

  // Strobe select resets to falling edge, as the pin's pull-down would
  localparam logic SEL_RESET = 1'b0;

endpackage

// ### verilog/lvdss_shifter.sv
`timescale 1ns/100ps
`default_nettype none

module lvdss_shifter (
  // Clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_i,
  // Control
  input  wire logic                                 clear_i,
  input  wire logic                                 load_i,
  input  wire logic                                 shift_i,
  input  wire logic [lvdss_pkg::BITS_PER_LANE-1:0]  word_i,
  // Differential bit
  output logic                                      pos_o,
  output logic                                      neg_o
);

  logic [lvdss_pkg::BITS_PER_LANE-1:0] sr_q;

  // First bit of the frame is the top bit of the word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_q <= '0;
    end else if (clear_i) begin
      sr_q <= '0;
    end else if (load_i) begin
      sr_q <= word_i;
    end else if (shift_i) begin
      sr_q <= {sr_q[lvdss_pkg::BITS_PER_LANE-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_o <= 1'b0;
      neg_o <= 1'b1;
    end else if (clear_i) begin
      pos_o <= 1'b0;
      neg_o <= 1'b1;
    end else if (load_i) begin
      pos_o <= word_i[lvdss_pkg::BITS_PER_LANE-1];
      neg_o <= ~word_i[lvdss_pkg::BITS_PER_LANE-1];
    end else if (shift_i) begin
      pos_o <= sr_q[lvdss_pkg::BITS_PER_LANE-2];
      neg_o <= ~sr_q[lvdss_pkg::BITS_PER_LANE-2];
    end
  end

endmodule

`default_nettype wire

// ### verilog/lvdss_top.sv
// Notes on behaviour
// - Capture 21 inputs per pixel clock: 18 colour bits, line, frame, valid.
// - Drive three serial data lanes and one forwarded clock lane, differential.
// - Strobe select high samples on rising edge, low on falling edge.
// - Strobe select defaults to falling edge when left unconnected.
// - Power-down low places all serial and clock outputs in high impedance.
// - Bit slots run at seven times the pixel clock rate.
// - Outputs start toggling 10 ms after power-down goes high.
// - Power-down takes effect at once, whatever frame is in progress.
`timescale 1ns/100ps
`default_nettype none

module lvdss_top #(
  parameter int unsigned LOCK_CYCLES = lvdss_pkg::LOCK_CYCLES_DEF
) (
  // System clock and reset
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          RST_I,
  // Parallel side from the host
  input  wire logic                          INPUT_PIXEL_CLOCK_I,
  input  wire lvdss_pkg::lvdss_pixel_s       PIXEL_I,
  input  wire logic                          STROBE_EDGE_SELECT_I,
  input  wire logic                          POWER_DOWN_N_I,
  // Serial data lanes
  output logic [lvdss_pkg::LANES-1:0]        SERIAL_LANE_POS_O,
  output logic [lvdss_pkg::LANES-1:0]        SERIAL_LANE_NEG_O,
  output logic                               SERIAL_LANE_OE_O,
  // Forwarded clock lane
  output logic                               FORWARDED_CLOCK_POS_O,
  output logic                               FORWARDED_CLOCK_NEG_O,
  output logic                               FORWARDED_CLOCK_OE_O
);

  localparam int unsigned PW = lvdss_pkg::PIN_W;

  logic [PW-1:0]                      pins;
  logic [PW-1:0]                      s1_q;
  logic [PW-1:0]                      s2_q;
  logic [PW-1:0]                      s3_q;
  logic                               clk_lvl_q;
  logic                               sel_q;
  logic                               pd_n_q;
  logic                               clk_change;
  logic                               strobe;
  logic [lvdss_pkg::PERIOD_W-1:0]     cnt_q;
  logic [lvdss_pkg::PERIOD_W-1:0]     period_q;
  logic                               seen_q;
  logic                               period_ok_q;
  logic [lvdss_pkg::LOCK_W-1:0]       lock_cnt_q;
  logic                               locked_q;
  logic                               load;
  logic                               advance;
  logic                               running_q;
  logic [lvdss_pkg::IDX_W-1:0]        idx_q;
  logic [lvdss_pkg::ACC_W-1:0]        acc_q;
  logic [lvdss_pkg::ACC_W-1:0]        acc_sum;
  logic [lvdss_pkg::PIXEL_BITS-1:0]   word;
  logic [lvdss_pkg::SHIFT_LANES-1:0]  lane_pos;
  logic [lvdss_pkg::SHIFT_LANES-1:0]  lane_neg;

  assign pins = {POWER_DOWN_N_I, STROBE_EDGE_SELECT_I, INPUT_PIXEL_CLOCK_I, PIXEL_I};

  // Three-stage sampling; only the second stage reads the first
  // Stages reset low like the idle pins, so no false edge follows reset
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A control pin changes only once stages two and three agree
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_lvl_q <= 1'b0;
      sel_q     <= lvdss_pkg::SEL_RESET;
      pd_n_q    <= 1'b0;
    end else begin
      if (s2_q[lvdss_pkg::PIN_CLK] == s3_q[lvdss_pkg::PIN_CLK]) begin
        clk_lvl_q <= s3_q[lvdss_pkg::PIN_CLK];
      end
      if (s2_q[lvdss_pkg::PIN_SEL] == s3_q[lvdss_pkg::PIN_SEL]) begin
        sel_q <= s3_q[lvdss_pkg::PIN_SEL];
      end
      if (s2_q[lvdss_pkg::PIN_PD] == s3_q[lvdss_pkg::PIN_PD]) begin
        pd_n_q <= s3_q[lvdss_pkg::PIN_PD];
      end
    end
  end

  // An edge counts once stages two and three agree on a level new to the block
  assign clk_change = (s2_q[lvdss_pkg::PIN_CLK] == s3_q[lvdss_pkg::PIN_CLK])
                    && (s3_q[lvdss_pkg::PIN_CLK] != clk_lvl_q);
  // Rising edge when select is high, falling edge when low
  assign strobe = clk_change && (s3_q[lvdss_pkg::PIN_CLK] == sel_q);

  // Limitation: the pixel period must be at least seven system cycles,
  // or the bit slots of one frame overrun the next strobe
  // Pixel period in system cycles; stands in for the multiplier's reference
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_q       <= '0;
      period_q    <= lvdss_pkg::PERIOD_MAX;
      seen_q      <= 1'b0;
      period_ok_q <= 1'b0;
    end else if (!pd_n_q) begin
      // Power-down also resets the multiplier
      cnt_q       <= '0;
      seen_q      <= 1'b0;
      period_ok_q <= 1'b0;
    end else if (strobe) begin
      cnt_q       <= '0;
      seen_q      <= 1'b1;
      if (seen_q) begin
        // A stalled pixel clock pins the period at its ceiling
        if (cnt_q == lvdss_pkg::PERIOD_MAX) begin
          period_q <= cnt_q;
        end else begin
          period_q <= cnt_q + 1'b1;
        end
        period_ok_q <= 1'b1;
      end
    end else if (cnt_q != lvdss_pkg::PERIOD_MAX) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Outputs stay quiet until the lock wait has run out
  // The counter is wide enough for the full wait at the system clock rate
  // A return from power-down repeats the whole wait
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else if (!pd_n_q) begin
      lock_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else if (!locked_q) begin
      if (lock_cnt_q >= lvdss_pkg::LOCK_W'(LOCK_CYCLES - 1)) begin
        locked_q <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end
    end
  end

  assign load = strobe && locked_q && period_ok_q;
  // Data pins need no agreement check: the host holds them steady around the strobe
  assign word = s3_q[lvdss_pkg::PIXEL_BITS-1:0];

  // Spread seven bit slots evenly over the measured period
  assign acc_sum = acc_q + lvdss_pkg::ACC_STEP;
  assign advance = running_q && (acc_sum >= {1'b0, period_q});

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      running_q <= 1'b0;
      idx_q     <= '0;
      acc_q     <= '0;
    end else if (!pd_n_q) begin
      running_q <= 1'b0;
      idx_q     <= '0;
      acc_q     <= '0;
    end else if (load) begin
      // Each load strobe restarts the frame so the lanes stay aligned to it
      running_q <= 1'b1;
      idx_q     <= '0;
      acc_q     <= '0;
    end else if (advance) begin
      // The seventh slot ends the frame without a shift; bit 0 stands until the next load
      acc_q <= acc_sum - {1'b0, period_q};
      if (idx_q == lvdss_pkg::LAST_BIT) begin
        running_q <= 1'b0;
      end else begin
        idx_q <= idx_q + 1'b1;
      end
    end else if (running_q) begin
      acc_q <= acc_sum;
    end
  end

  // Lanes 0..2 carry the word in 7-bit slices; the last shifter is the clock
  // Clear holds every pair at its idle level until the multiplier is locked
  // Every lane shifts on the same slot strobe so the pairs stay in step
  for (genvar k = 0; k < lvdss_pkg::SHIFT_LANES; k++) begin : g_lane
    logic [lvdss_pkg::BITS_PER_LANE-1:0] lane_word;
    if (k < lvdss_pkg::LANES) begin : g_data
      assign lane_word = word[k*lvdss_pkg::BITS_PER_LANE +: lvdss_pkg::BITS_PER_LANE];
    end else begin : g_fwd
      assign lane_word = lvdss_pkg::FWD_CLK_PATTERN;
    end
    lvdss_shifter u_shift (
      .clk_i   (SYS_CLK_I),
      .rst_i   (RST_I),
      .clear_i (!locked_q),
      .load_i  (load),
      .shift_i (advance && (idx_q != lvdss_pkg::LAST_BIT)),
      .word_i  (lane_word),
      .pos_o   (lane_pos[k]),
      .neg_o   (lane_neg[k])
    );
  end

  assign SERIAL_LANE_POS_O     = lane_pos[lvdss_pkg::LANES-1:0];
  assign SERIAL_LANE_NEG_O     = lane_neg[lvdss_pkg::LANES-1:0];
  assign FORWARDED_CLOCK_POS_O = lane_pos[lvdss_pkg::LANES];
  assign FORWARDED_CLOCK_NEG_O = lane_neg[lvdss_pkg::LANES];

  // The raw pin gates the drivers so that power-down needs no clock edge
  // Reset also releases the pairs, so the lines float while the block is held
  assign SERIAL_LANE_OE_O      = POWER_DOWN_N_I && !RST_I;
  assign FORWARDED_CLOCK_OE_O  = POWER_DOWN_N_I && !RST_I;

endmodule

`default_nettype wire

// ### verif/lvdss_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lvdss_props #(parameter int unsigned LOCK_CYCLES = 50) (
  // Clock, reset and power down
  input wire logic       SYS_CLK_I,
  input wire logic       RST_I,
  input wire logic       POWER_DOWN_N_I,
  // Serial outputs
  input wire logic [2:0] SERIAL_LANE_POS_O,
  input wire logic [2:0] SERIAL_LANE_NEG_O,
  input wire logic       SERIAL_LANE_OE_O,
  input wire logic       FORWARDED_CLOCK_POS_O,
  input wire logic       FORWARDED_CLOCK_NEG_O,
  input wire logic       FORWARDED_CLOCK_OE_O
);
  // Pixel period of the bench in system cycles
  localparam int unsigned PIX_CYC = 20;
  int unsigned pd_cnt_q;
  logic [7:0]  gap_q;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I || !POWER_DOWN_N_I) pd_cnt_q <= 0;
    else if (pd_cnt_q < LOCK_CYCLES) pd_cnt_q <= pd_cnt_q + 1;
  end
  // Cycles since the last clock fall; 0 means no fall seen since power up
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I || !POWER_DOWN_N_I) gap_q <= 8'h00;
    else if ($fell(FORWARDED_CLOCK_POS_O)) gap_q <= 8'h01;
    else if (gap_q != 8'h00 && gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  oe_follow_a: assert property (SERIAL_LANE_OE_O == POWER_DOWN_N_I)
    else $error("lane enable not following power down");
  oe_pair_a: assert property (FORWARDED_CLOCK_OE_O == SERIAL_LANE_OE_O)
    else $error("clock and lane enables differ");
  lane_diff_a: assert property (SERIAL_LANE_NEG_O == ~SERIAL_LANE_POS_O)
    else $error("lane pair not complementary");
  clk_diff_a: assert property (FORWARDED_CLOCK_NEG_O != FORWARDED_CLOCK_POS_O)
    else $error("clock pair not complementary");
  lock_wait_a: assert property (pd_cnt_q inside {[1:LOCK_CYCLES-1]} |->
    !FORWARDED_CLOCK_POS_O && SERIAL_LANE_POS_O == 3'h0) else $error("output before lock");
  clk_period_a: assert property ($fell(FORWARDED_CLOCK_POS_O) && gap_q != 8'h00 |->
    gap_q == PIX_CYC) else $error("clock frame period wrong");
  low_run_a: assert property ($fell(FORWARDED_CLOCK_POS_O) |->
    !FORWARDED_CLOCK_POS_O [*8]) else $error("clock low run too short");
  high_run_a: assert property ($rose(FORWARDED_CLOCK_POS_O) && POWER_DOWN_N_I |->
    FORWARDED_CLOCK_POS_O [*6]) else $error("clock high run too short");
  cover property ($fell(FORWARDED_CLOCK_POS_O) && gap_q == PIX_CYC);
  cover property ($fell(SERIAL_LANE_OE_O));
  cover property (pd_cnt_q == LOCK_CYCLES && $rose(FORWARDED_CLOCK_POS_O));
endmodule
bind lvdss_top lvdss_props #(.LOCK_CYCLES(LOCK_CYCLES)) props_u (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .POWER_DOWN_N_I(POWER_DOWN_N_I),
  .SERIAL_LANE_POS_O(SERIAL_LANE_POS_O), .SERIAL_LANE_NEG_O(SERIAL_LANE_NEG_O),
  .SERIAL_LANE_OE_O(SERIAL_LANE_OE_O), .FORWARDED_CLOCK_POS_O(FORWARDED_CLOCK_POS_O),
  .FORWARDED_CLOCK_NEG_O(FORWARDED_CLOCK_NEG_O), .FORWARDED_CLOCK_OE_O(FORWARDED_CLOCK_OE_O));
`default_nettype wire

// ### verif/lvdss_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module lvdss_rx_model (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Serial lanes
  input  wire logic [2:0]             lane_i,
  input  wire logic                   fwd_i,
  input  wire logic                   oe_i,
  // Recovered word
  output var lvdss_pkg::lvdss_pixel_s word_o,
  output logic                        valid_o
);
  logic [53:0] hist_q;
  logic [20:0] word_d;
  logic        fwd_q;
  logic [3:0]  cnt_q;
  always_ff @(posedge clk_i) hist_q <= {hist_q[50:0], lane_i};
  // Slots assume a 20-cycle pixel period: one bit per 3 cycles, bit 4 at the clock fall
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 6; b++) word_d[7*k+6-b] = hist_q[51-9*b+k];
      word_d[7*k] = lane_i[k];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {fwd_q, cnt_q, valid_o} <= 6'h00;
    end else begin
      fwd_q <= fwd_i;
      cnt_q <= (oe_i && fwd_q && !fwd_i) ? 4'hC : cnt_q - {3'h0, cnt_q != 4'h0};
      valid_o <= cnt_q == 4'h1;
      if (cnt_q == 4'h1) word_o <= lvdss_pkg::lvdss_pixel_s'(word_d);
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned LOCK = 50;
  logic                    clk, rst, pclk, pclk_en, sel, pd_n, oe, fwd_oe, fwd_p, fwd_n, rx_valid;
  logic [2:0]              lane_p, lane_n;
  logic [20:0]             cur;
  lvdss_pkg::lvdss_pixel_s pix, rx_word;
  int unsigned             failures, n_compared;
  logic [20:0] words [5] = '{21'h1F8000, 21'h007E00, 21'h0001F8, 21'h000007, 21'h155AA5};
  lvdss_top #(.LOCK_CYCLES(LOCK)) dut_u (
    .SYS_CLK_I(clk), .RST_I(rst), .INPUT_PIXEL_CLOCK_I(pclk), .PIXEL_I(pix),
    .STROBE_EDGE_SELECT_I(sel), .POWER_DOWN_N_I(pd_n), .SERIAL_LANE_POS_O(lane_p),
    .SERIAL_LANE_NEG_O(lane_n), .SERIAL_LANE_OE_O(oe), .FORWARDED_CLOCK_POS_O(fwd_p),
    .FORWARDED_CLOCK_NEG_O(fwd_n), .FORWARDED_CLOCK_OE_O(fwd_oe));
  lvdss_rx_model rx_u (.clk_i(clk), .rst_i(rst), .lane_i(lane_p), .fwd_i(fwd_p), .oe_i(oe),
    .word_o(rx_word), .valid_o(rx_valid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pixel clock stands still while disabled
  initial begin
    pclk = 1'b0;
    forever begin
      repeat (10) @(negedge clk);
      if (pclk_en) pclk = ~pclk;
    end
  end
  // Word ahead of the strobe edge, its inverse after it, so a wrong edge shows
  always @(pclk) begin
    if (pclk == sel) repeat (5) @(negedge clk);
    else @(negedge clk);
    pix = lvdss_pkg::lvdss_pixel_s'((pclk == sel) ? ~cur : cur);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_frames(input logic s);
    int n;
    sel = s;
    pclk_en = 1'b1;
    repeat (40) @(negedge clk);
    pd_n = 1'b1;
    repeat (LOCK / 2) @(negedge clk);
    check({oe, fwd_p, lane_p}, 5'h10);
    foreach (words[i]) begin
      cur = words[i];
      // The third frame after the change surely carries the new word
      for (int f = 0; f < 3; f++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (rx_valid !== 1'b1 && n < 120);
      end
      check(rx_word, words[i]);
    end
  endtask
  task automatic t_pdown;
    @(negedge fwd_p);
    repeat (2) @(negedge clk);
    pd_n = 1'b0;
    #1;
    check({oe, fwd_oe}, 2'h0);
    repeat (10) @(negedge clk);
    check({lane_p, fwd_p, lane_n, fwd_n}, 8'h0F);
    pclk_en = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  initial begin
    failures = 0;
    n_compared = 0;
    {rst, pd_n, sel, pclk_en, cur} = {1'b1, 24'h0};
    pix = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({oe, fwd_oe, lane_p, fwd_p, lane_n, fwd_n}, 10'h00F);
    t_frames(1'b0);
    t_pdown;
    t_frames(1'b1);
    print_verdict;
  end
  // Both power-ups and ten words take near 900 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
